// file: rtl/ecr_pkg.sv
package ecr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ECR_OFS_YEAR_STAMP   = 8'h1a;
    localparam logic [7:0] ECR_OFS_EPOCH_BYTE0  = 8'h1b;
    localparam logic [7:0] ECR_OFS_EPOCH_BYTE1  = 8'h1c;
    localparam logic [7:0] ECR_OFS_EPOCH_BYTE2  = 8'h1d;
    localparam logic [7:0] ECR_OFS_EPOCH_BYTE3  = 8'h1e;
    localparam logic [7:0] ECR_OFS_SCRATCH_A    = 8'h1f;
    localparam logic [7:0] ECR_OFS_SCRATCH_B    = 8'h20;

    // ------------------------------------------------------------------
    // Widths, reset values and codes
    // ------------------------------------------------------------------
    localparam int         ECR_EPOCH_W          = 32;
    localparam int         ECR_EPOCH_BYTES      = 4;
    localparam logic [7:0] ECR_BYTE_RST         = 8'h00;
    localparam logic [31:0] ECR_EPOCH_RST       = 32'h0000_0000;
    localparam logic [31:0] ECR_EPOCH_ONE       = 32'h0000_0001;
    localparam logic [7:0] ECR_PROTECT_CODE_ON  = 8'hff;
    localparam logic [3:0] ECR_BCD_MAX_DIGIT    = 4'h9;
    localparam logic [7:0] ECR_RDATA_UNMAPPED   = 8'h00;

    // One register access from the serial bus engine.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ecr_req_t;

    // Timestamp capture controls from the event logic.
    typedef struct packed {
        logic       capture_enable;
        logic       overwrite_select;
        logic       clear_trigger;
        logic       event_pulse;
        logic [7:0] year_bcd;
    } ecr_stamp_t;

endpackage

// file: rtl/ecr_regs.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Year stamp holds two BCD digits 00-99.
// - Year stamp is read-only; writes change nothing.
// - Epoch count is one 32-bit unsigned value.
// - Epoch count wraps from all ones to zero.
// - Epoch count advances once per 1 Hz tick.
// - Increments suppressed while host writes counter bytes.
// - Counter bytes read live, load written byte.
// - Protection blocks counter and RAM writes only.
// - Counter bytes mapped LSB first, 1Bh to 1Eh.
// - Two user RAM bytes at 1Fh and 20h.
// - Protection active only when code is 255.
module ecr_regs
    import ecr_pkg::*;
(
    input  wire logic       I_CORE_CLK,
    input  wire logic       I_NRST,
    input  wire ecr_req_t   I_REQ,
    input  wire logic       I_EPOCH_WR_BUSY,
    input  wire logic       I_TICK_1HZ,
    input  wire ecr_stamp_t I_STAMP,
    input  wire logic [7:0] I_PROTECT_ENABLE_CODE,
    input  wire logic       I_PASSWORD_MATCH,
    output logic [7:0]      O_RDATA,
    output logic            O_RVALID,
    output logic [31:0]     O_EPOCH_COUNT,
    output logic            O_WRITE_PROTECTED
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_epoch_ofs(input logic [7:0] a);
        return (a >= ECR_OFS_EPOCH_BYTE0) && (a <= ECR_OFS_EPOCH_BYTE3);
    endfunction

    function automatic logic [1:0] epoch_lane(input logic [7:0] a);
        logic [7:0] d;
        d = a - ECR_OFS_EPOCH_BYTE0;
        return d[1:0];
    endfunction

    logic [31:0] epoch;
    logic [31:0] next_epoch;
    logic [7:0]  scratch_a;
    logic [7:0]  scratch_b;
    logic [7:0]  year_stamp;
    logic        stamp_held;
    logic        protect_on;
    logic        wr_ok;
    logic        epoch_wr;
    logic        inc_inhibit;
    logic        capture_now;

    // ------------------------------------------------------------------
    // Write protection
    // ------------------------------------------------------------------
    // The password compare lives elsewhere; only its verdict is used here.
    assign protect_on  = (I_PROTECT_ENABLE_CODE == ECR_PROTECT_CODE_ON) &&
                         !I_PASSWORD_MATCH;
    assign wr_ok       = I_REQ.wr && !protect_on;
    assign epoch_wr    = wr_ok && is_epoch_ofs(I_REQ.addr);
    // The strobe itself also inhibits, in case the busy level arrives late.
    assign inc_inhibit = I_EPOCH_WR_BUSY || (I_REQ.wr && is_epoch_ofs(I_REQ.addr));

    // ------------------------------------------------------------------
    // Epoch-seconds counter
    // ------------------------------------------------------------------
    always_comb begin
        next_epoch = epoch;
        if (epoch_wr) begin
            next_epoch[epoch_lane(I_REQ.addr)*8 +: 8] = I_REQ.wdata;
        end else if (I_TICK_1HZ && !inc_inhibit) begin
            // Plain 32-bit addition drops the carry, so all ones wraps to zero.
            next_epoch = epoch + ECR_EPOCH_ONE;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            epoch <= ECR_EPOCH_RST;
        end else begin
            epoch <= next_epoch;
        end
    end

    // ------------------------------------------------------------------
    // User RAM bytes
    // ------------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            scratch_a <= ECR_BYTE_RST;
            scratch_b <= ECR_BYTE_RST;
        end else if (wr_ok) begin
            if (I_REQ.addr == ECR_OFS_SCRATCH_A) begin
                scratch_a <= I_REQ.wdata;
            end
            if (I_REQ.addr == ECR_OFS_SCRATCH_B) begin
                scratch_b <= I_REQ.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Year timestamp
    // ------------------------------------------------------------------
    // No write path reaches this byte, so host writes to it simply fall away.
    // Clearing frees the slot at once, so an event in the clearing cycle is never lost.
    assign capture_now = I_STAMP.capture_enable && I_STAMP.event_pulse &&
                         (I_STAMP.overwrite_select || !stamp_held ||
                          I_STAMP.clear_trigger);

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            year_stamp <= ECR_BYTE_RST;
            stamp_held <= 1'b0;
        end else if (capture_now) begin
            year_stamp <= I_STAMP.year_bcd;
            stamp_held <= 1'b1;
        end else if (I_STAMP.clear_trigger) begin
            year_stamp <= ECR_BYTE_RST;
            stamp_held <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Reads are never protected; unmapped offsets answer zero.
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_RDATA <= ECR_RDATA_UNMAPPED;
        end else if (I_REQ.rd) begin
            if (is_epoch_ofs(I_REQ.addr)) begin
                O_RDATA <= epoch[epoch_lane(I_REQ.addr)*8 +: 8];
            end else if (I_REQ.addr == ECR_OFS_YEAR_STAMP) begin
                O_RDATA <= year_stamp;
            end else if (I_REQ.addr == ECR_OFS_SCRATCH_A) begin
                O_RDATA <= scratch_a;
            end else if (I_REQ.addr == ECR_OFS_SCRATCH_B) begin
                O_RDATA <= scratch_b;
            end else begin
                O_RDATA <= ECR_RDATA_UNMAPPED;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_RVALID <= 1'b0;
        end else begin
            O_RVALID <= I_REQ.rd;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_WRITE_PROTECTED <= 1'b0;
        end else begin
            O_WRITE_PROTECTED <= protect_on;
        end
    end

    assign O_EPOCH_COUNT = epoch;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);

    chk_epoch_tick_step: assert property (
        I_TICK_1HZ && !inc_inhibit && !I_REQ.wr |=> epoch == $past(epoch) + ECR_EPOCH_ONE)
        else $error("epoch count did not advance on tick");

    chk_epoch_wrap_zero: assert property (
        I_TICK_1HZ && !inc_inhibit && !I_REQ.wr && (&epoch) |=> epoch == ECR_EPOCH_RST)
        else $error("epoch count did not wrap to zero");

    chk_epoch_hold_busy: assert property (
        I_EPOCH_WR_BUSY && !I_REQ.wr |=> $stable(epoch))
        else $error("epoch count moved during host write");

    chk_epoch_byte_load: assert property (
        wr_ok && I_REQ.addr == ECR_OFS_EPOCH_BYTE3 |=> epoch[31:24] == $past(I_REQ.wdata))
        else $error("top epoch byte not loaded");

    chk_lsb_first_map: assert property (
        I_REQ.rd && I_REQ.addr == ECR_OFS_EPOCH_BYTE0 && !I_REQ.wr && !I_TICK_1HZ
        |=> O_RVALID && O_RDATA == epoch[7:0])
        else $error("lowest epoch byte not at first offset");

    chk_protect_blocks_ram: assert property (
        I_REQ.wr && protect_on |=> $stable(scratch_a) && $stable(scratch_b))
        else $error("user RAM written while protected");

    chk_protect_code_only: assert property (
        I_PROTECT_ENABLE_CODE != ECR_PROTECT_CODE_ON |=> !O_WRITE_PROTECTED)
        else $error("protection active without enable code");

    chk_ram_write_open: assert property (
        wr_ok && I_REQ.addr == ECR_OFS_SCRATCH_B |=> scratch_b == $past(I_REQ.wdata))
        else $error("second user RAM byte not written");

    chk_stamp_readonly: assert property (
        I_REQ.wr && I_REQ.addr == ECR_OFS_YEAR_STAMP && !I_STAMP.event_pulse
        && !I_STAMP.clear_trigger |=> $stable(year_stamp))
        else $error("year stamp changed by host write");

    chk_stamp_first_kept: assert property (
        stamp_held && !I_STAMP.overwrite_select && !I_STAMP.clear_trigger |=> $stable(year_stamp))
        else $error("first-event stamp was overwritten");

    chk_stamp_bcd_range: assert property (
        year_stamp[7:4] <= ECR_BCD_MAX_DIGIT && year_stamp[3:0] <= ECR_BCD_MAX_DIGIT)
        else $error("year stamp is not two BCD digits");

    // ------------------------------------------------------------------
    // Checks on the counter lanes
    // ------------------------------------------------------------------
    chk_epoch_idle_hold: assert property (
        !I_TICK_1HZ && !I_REQ.wr |=> $stable(epoch))
        else $error("epoch count moved without tick or write");

    chk_epoch_strobe_inhibit: assert property (
        I_TICK_1HZ && epoch_wr && I_REQ.addr == ECR_OFS_EPOCH_BYTE0
        |=> $stable(epoch[31:8]) && epoch[7:0] == $past(I_REQ.wdata))
        else $error("tick leaked into a host counter write");

    chk_epoch_lane0_load: assert property (
        wr_ok && I_REQ.addr == ECR_OFS_EPOCH_BYTE0 |=> epoch[7:0] == $past(I_REQ.wdata))
        else $error("lowest epoch byte not loaded");

    chk_epoch_lane1_load: assert property (
        wr_ok && I_REQ.addr == ECR_OFS_EPOCH_BYTE1 |=> epoch[15:8] == $past(I_REQ.wdata))
        else $error("second epoch byte not loaded");

    chk_epoch_lane2_load: assert property (
        wr_ok && I_REQ.addr == ECR_OFS_EPOCH_BYTE2 |=> epoch[23:16] == $past(I_REQ.wdata))
        else $error("third epoch byte not loaded");

    chk_epoch_lane_only: assert property (
        wr_ok && I_REQ.addr == ECR_OFS_EPOCH_BYTE0 |=> $stable(epoch[31:8]))
        else $error("epoch write disturbed other bytes");

    chk_protect_blocks_epoch: assert property (
        I_REQ.wr && protect_on && !I_TICK_1HZ |=> $stable(epoch))
        else $error("epoch count written while protected");

    // ------------------------------------------------------------------
    // Checks on the read path
    // ------------------------------------------------------------------
    chk_rvalid_on_read: assert property (
        I_REQ.rd |=> O_RVALID)
        else $error("read not answered");

    chk_rvalid_one_cycle: assert property (
        !I_REQ.rd |=> !O_RVALID)
        else $error("read answer without a read");

    chk_rdata_hold: assert property (
        !I_REQ.rd |=> $stable(O_RDATA))
        else $error("read data changed without a read");

    chk_read_lane1: assert property (
        I_REQ.rd && I_REQ.addr == ECR_OFS_EPOCH_BYTE1 && !I_REQ.wr && !I_TICK_1HZ
        |=> O_RDATA == epoch[15:8])
        else $error("second epoch byte read from wrong lane");

    chk_read_lane3: assert property (
        I_REQ.rd && I_REQ.addr == ECR_OFS_EPOCH_BYTE3 && !I_REQ.wr && !I_TICK_1HZ
        |=> O_RDATA == epoch[31:24])
        else $error("top epoch byte read from wrong lane");

    chk_read_ram_a: assert property (
        I_REQ.rd && I_REQ.addr == ECR_OFS_SCRATCH_A && !I_REQ.wr |=> O_RDATA == scratch_a)
        else $error("first user RAM byte read wrong");

    chk_read_ram_b: assert property (
        I_REQ.rd && I_REQ.addr == ECR_OFS_SCRATCH_B && !I_REQ.wr |=> O_RDATA == scratch_b)
        else $error("second user RAM byte read wrong");

    chk_read_stamp: assert property (
        I_REQ.rd && I_REQ.addr == ECR_OFS_YEAR_STAMP |=> O_RDATA == $past(year_stamp))
        else $error("year stamp read wrong");

    // ------------------------------------------------------------------
    // Checks on the timestamp and protection
    // ------------------------------------------------------------------
    chk_stamp_clear_zero: assert property (
        I_STAMP.clear_trigger && !I_STAMP.event_pulse |=> year_stamp == ECR_BYTE_RST)
        else $error("year stamp not cleared");

    chk_stamp_event_wins: assert property (
        I_STAMP.capture_enable && I_STAMP.event_pulse && I_STAMP.clear_trigger
        |=> year_stamp == $past(I_STAMP.year_bcd))
        else $error("event lost in the clearing cycle");

    chk_stamp_last_taken: assert property (
        I_STAMP.capture_enable && I_STAMP.event_pulse && I_STAMP.overwrite_select
        |=> year_stamp == $past(I_STAMP.year_bcd))
        else $error("last event not recorded");

    chk_stamp_disabled: assert property (
        !I_STAMP.capture_enable && !I_STAMP.clear_trigger |=> $stable(year_stamp))
        else $error("year stamp moved while capture disabled");

    chk_protect_flag_on: assert property (
        I_PROTECT_ENABLE_CODE == ECR_PROTECT_CODE_ON && !I_PASSWORD_MATCH
        |=> O_WRITE_PROTECTED)
        else $error("protection not reported");

    chk_protect_match_open: assert property (
        I_PROTECT_ENABLE_CODE == ECR_PROTECT_CODE_ON && I_PASSWORD_MATCH
        |=> !O_WRITE_PROTECTED)
        else $error("protection kept after password match");

    chk_ram_a_write_open: assert property (
        wr_ok && I_REQ.addr == ECR_OFS_SCRATCH_A |=> scratch_a == $past(I_REQ.wdata))
        else $error("first user RAM byte not written");

endmodule

// file: verif/ecr_host_model.sv
`timescale 1ns/1ps

module ecr_host_model
    import ecr_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output ecr_req_t        o_req,
    output logic            o_busy
);
    initial begin
        o_req  = '0;
        o_busy = 1'b0;
    end
    // A released data byte shows its inverse, so a stale value is never mistaken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) #1;
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk) #1;
        o_req.wr    = 1'b0;
        o_req.wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_clk) #1;
        o_req.addr = a;
        o_req.rd   = 1'b1;
        @(posedge i_clk) #1;
        o_req.rd = 1'b0;
        d        = i_rdata;
        v        = i_rvalid;
    endtask
    task automatic hold(input logic b);
        @(posedge i_clk) #1;
        o_busy = b;
    endtask
    // The engine keeps busy high across all four bytes so no tick splits them.
    task automatic wr_epoch(input logic [31:0] v);
        hold(1'b1);
        for (int i = 0; i < 4; i++) wr(ECR_OFS_EPOCH_BYTE0 + 8'(i), v[8*i+:8]);
        hold(1'b0);
    endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps

module testbench
    import ecr_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       tick_1hz = 1'b0, ev = 1'b0, clr = 1'b0, cap = 1'b0, ows = 1'b0;
    logic [7:0] year = 8'h00, code = 8'h00;
    logic       match = 1'b0;
    ecr_req_t   req;
    ecr_stamp_t stamp;
    logic       busy, rvalid, wprot;
    logic [7:0] rdata;
    logic [31:0] cnt;
    int         n_fail = 0, num_checks = 0, cyc = 0;

    always #2 clk = ~clk;
    assign stamp = '{cap, ows, clr, ev, year};

    ecr_host_model u_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
                           .o_req(req), .o_busy(busy));
    ecr_regs dut (.I_CORE_CLK(clk), .I_NRST(rst_n), .I_REQ(req), .I_EPOCH_WR_BUSY(busy),
                  .I_TICK_1HZ(tick_1hz), .I_STAMP(stamp), .I_PROTECT_ENABLE_CODE(code),
                  .I_PASSWORD_MATCH(match), .O_RDATA(rdata), .O_RVALID(rvalid),
                  .O_EPOCH_COUNT(cnt), .O_WRITE_PROTECTED(wprot));

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        u_host.rd(a, d, v);
        chk("rvalid", {31'h0, v}, 32'h1);
        chk($sformatf("reg %h", a), {24'h0, d}, {24'h0, exp});
    endtask
    // Kind 0 is the one-second tick, 1 a stamp event, 2 a stamp clear, 3 event and clear.
    task automatic pulse(input int k);
        @(posedge clk) #1;
        tick_1hz = (k == 0);
        ev       = (k == 1) || (k == 3);
        clr      = (k == 2) || (k == 3);
        @(posedge clk) #1;
        {tick_1hz, ev, clr} = 3'b000;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int a = 8'h1a; a <= 8'h21; a++) rchk(8'(a), ECR_BYTE_RST);
        u_host.wr_epoch(32'h1234_5678);
        chk("count", cnt, 32'h1234_5678);
        for (int i = 0; i < 4; i++) rchk(ECR_OFS_EPOCH_BYTE0 + 8'(i), 8'h78 + 8'(i) * 8'hde);
        u_host.hold(1'b1);
        pulse(0);
        u_host.hold(1'b0);
        chk("count", cnt, 32'h1234_5678);
        pulse(0);
        chk("count", cnt, 32'h1234_5679);
        u_host.wr_epoch(32'hffff_ffff);
        pulse(0);
        chk("count", cnt, 32'h0);
        u_host.wr(ECR_OFS_SCRATCH_A, 8'ha5);
        u_host.wr(ECR_OFS_SCRATCH_B, 8'h5a);
        rchk(ECR_OFS_SCRATCH_A, 8'ha5);
        rchk(ECR_OFS_SCRATCH_B, 8'h5a);
        code = ECR_PROTECT_CODE_ON;
        u_host.wr(ECR_OFS_SCRATCH_A, 8'h3c);
        u_host.wr(ECR_OFS_EPOCH_BYTE1, 8'h55);
        chk("wprot", {31'h0, wprot}, 32'h1);
        chk("count", cnt, 32'h0);
        rchk(ECR_OFS_SCRATCH_A, 8'ha5);
        match = 1'b1;
        u_host.wr(ECR_OFS_SCRATCH_A, 8'h3c);
        rchk(ECR_OFS_SCRATCH_A, 8'h3c);
        match = 1'b0;
        code  = 8'hfe;
        u_host.wr(ECR_OFS_SCRATCH_B, 8'h11);
        rchk(ECR_OFS_SCRATCH_B, 8'h11);
        fork
            u_host.wr(ECR_OFS_EPOCH_BYTE0, 8'h10);
            pulse(0);
        join
        chk("count", cnt, 32'h0000_0010);
        u_host.wr(ECR_OFS_YEAR_STAMP, 8'h99);
        rchk(ECR_OFS_YEAR_STAMP, 8'h00);
        cap  = 1'b1;
        year = 8'h23;
        pulse(1);
        rchk(ECR_OFS_YEAR_STAMP, 8'h23);
        year = 8'h45;
        pulse(1);
        rchk(ECR_OFS_YEAR_STAMP, 8'h23);
        ows  = 1'b1;
        year = 8'h99;
        pulse(1);
        rchk(ECR_OFS_YEAR_STAMP, 8'h99);
        pulse(2);
        rchk(ECR_OFS_YEAR_STAMP, 8'h00);
        ows  = 1'b0;
        year = 8'h31;
        pulse(1);
        year = 8'h42;
        pulse(3);
        rchk(ECR_OFS_YEAR_STAMP, 8'h42);
        cap  = 1'b0;
        year = 8'h55;
        pulse(1);
        rchk(ECR_OFS_YEAR_STAMP, 8'h42);
        rst_n = 1'b0;
        @(posedge clk) #1;
        rst_n = 1'b1;
        chk("count", cnt, 32'h0);
        rchk(ECR_OFS_SCRATCH_B, ECR_BYTE_RST);
        rchk(ECR_OFS_YEAR_STAMP, ECR_BYTE_RST);
        finish_test();
    end
endmodule
